//--- logic/sst_pkg.sv
// Shared constants and types for the target status/disconnect sequencer.
// Assumes a single 10 MHz clock and a classic Wishbone register port.
package sst_pkg;
  // ---------------------------------------------------------------
  // Command codes written to the command register
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_COMPLETE = 8'h0D;
  localparam logic [7:0] CMD_DISCONNECT_MSG = 8'h0E;
  localparam logic [7:0] CMD_DISCONNECT = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Message bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] MSG_CMD_COMPLETE = 8'h00;
  localparam logic [7:0] MSG_LINKED = 8'h0A;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0B;
  localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
  localparam logic [7:0] MSG_DISCONNECT = 8'h04;
  // ---------------------------------------------------------------
  // Progress codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PH_NONE = 8'h00;
  localparam logic [7:0] PH_CMD = 8'h30;
  localparam logic [7:0] PH_SDP = 8'h41;
  localparam logic [7:0] PH_DISC = 8'h42;
  localparam logic [7:0] PH_FREE = 8'h43;
  localparam logic [7:0] PH_STATUS = 8'h50;
  localparam logic [7:0] PH_CC = 8'h60;
  localparam logic [7:0] PH_LCC = 8'h61;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS_HOLD = 8'h04;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_PHASE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1C;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_SDP_BIT = 1;
  localparam int CTRL_AUTO_DISC_BIT = 2;
  localparam int CTRL_CONN_BIT = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FREE_BIT = 1;
  localparam int IRQ_TERM_BIT = 2;
  localparam int IRQ_INVALID_BIT = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] CDB_LEN_6 = 4'h6;
  localparam logic [3:0] CDB_LEN_10 = 4'hA;
  localparam logic [3:0] CDB_LEN_12 = 4'hC;

  typedef enum logic [2:0] {
    S_IDLE, S_STAT, S_MSG, S_SDP, S_DISC, S_CDB, S_WAIT, S_FREE
  } sst_state_e;

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_REQ, H_REL} sst_hs_e;
endpackage

//--- logic/sst_reqack.sv
// One-byte REQ/ACK handshake engine for the target side.
// Assumes ack and data inputs are already synchronised by the caller.
`timescale 1ns/1ns
module sst_reqack
  import sst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic dir_out,
  input wire logic [7:0] tx_byte,
  input wire logic abort,
  input wire logic ack_s,
  input wire logic [7:0] db_s,
  output logic req,
  output logic [7:0] db_o,
  output logic db_oe,
  output logic [7:0] rx_byte,
  output logic done
);
  sst_hs_e hs_ff;

  // -----------------------------------------------------------------
  // Handshake sequence
  // -----------------------------------------------------------------
  // Data is put out one cycle before REQ so the initiator sees it settled.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst || abort) begin
      hs_ff <= H_IDLE;
      req <= 1'b0;
      db_oe <= 1'b0;
      db_o <= RST_BYTE;
      rx_byte <= RST_BYTE;
    end else begin
      case (hs_ff)
        H_IDLE: begin
          if (start) begin
            db_o <= tx_byte;
            db_oe <= dir_out;
            hs_ff <= H_SETUP;
          end
        end
        H_SETUP: begin
          req <= 1'b1;
          hs_ff <= H_REQ;
        end
        H_REQ: begin
          if (ack_s) begin
            rx_byte <= db_s;
            req <= 1'b0;
            hs_ff <= H_REL;
          end
        end
        H_REL: begin
          if (!ack_s) begin
            db_oe <= 1'b0;
            done <= 1'b1;
            hs_ff <= H_IDLE;
          end
        end
        default: hs_ff <= H_IDLE;
      endcase
    end
  end
endmodule

//--- logic/sst_top.sv
// Target-role sequencer for the status/complete and disconnect commands.
// Assumes a classic Wishbone master and an initiator that keeps the
// REQ/ACK handshake; SCSI inputs are asynchronous and synchronised here.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module sst_top
  import sst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic scsi_ack_i,
  input wire logic scsi_atn_i,
  input wire logic [7:0] scsi_db_i,
  output logic [7:0] scsi_db_o,
  output logic scsi_db_oe,
  output logic scsi_req_o,
  output logic scsi_bsy_o,
  output logic scsi_cd_o,
  output logic scsi_io_o,
  output logic scsi_msg_o,
  output logic [7:0] cdb_byte_o,
  output logic cdb_valid_o
);
  import sst_pkg::*;

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
    end else begin
      sync1_ff <= {scsi_atn_i, scsi_ack_i, scsi_db_i};
      sync2_ff <= sync1_ff;
    end
  end
  wire atn_s = sync2_ff[9];
  wire ack_s = sync2_ff[8];
  wire [7:0] db_s = sync2_ff[7:0];

  // -----------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------
  logic [7:0] status_hold_reg_ff;
  logic [7:0] link_control_reg_ff;
  logic [2:0] ctrl_ff;
  logic conn_ff;
  logic [7:0] phase_ff;
  logic [3:0] irq_status_ff;
  logic [3:0] irq_mask_ff;
  sst_state_e state_ff;
  sst_state_e cur_ff;

  wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_lo = wb_hit && wb_we_i && wb_sel_i[0];
  wire wr_cmd = wr_lo && (wb_adr_i == OFS_CMD);
  wire wr_status = wr_lo && (wb_adr_i == OFS_STATUS_HOLD);
  wire wr_link = wr_lo && (wb_adr_i == OFS_LINK_CTRL);
  wire wr_ctrl = wr_lo && (wb_adr_i == OFS_CTRL);
  wire wr_phase = wr_lo && (wb_adr_i == OFS_PHASE);
  wire wr_mask = wr_lo && (wb_adr_i == OFS_IRQ_MASK);
  wire rd_irq = wb_hit && !wb_we_i && (wb_adr_i == OFS_IRQ_STATUS);
  wire [7:0] cmd_code = wb_dat_i[7:0];
  wire halt_on_attention_bit = ctrl_ff[CTRL_HALT_BIT];
  wire save_pointer_before_disconnect_bit = ctrl_ff[CTRL_SDP_BIT];
  wire busy = (state_ff != S_IDLE);
  wire [7:0] rd_data =
    (wb_adr_i == OFS_STATUS_HOLD) ? status_hold_reg_ff :
    (wb_adr_i == OFS_LINK_CTRL) ? link_control_reg_ff :
    (wb_adr_i == OFS_CTRL) ? {4'h0, conn_ff, ctrl_ff} :
    (wb_adr_i == OFS_PHASE) ? phase_ff :
    (wb_adr_i == OFS_IRQ_STATUS) ? {4'h0, irq_status_ff} :
    (wb_adr_i == OFS_IRQ_MASK) ? {4'h0, irq_mask_ff} :
    (wb_adr_i == OFS_STATE) ? {6'h00, conn_ff, busy} : RST_BYTE;

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_hold_reg_ff <= RST_BYTE;
      link_control_reg_ff <= RST_BYTE;
      ctrl_ff <= 3'h0;
      irq_mask_ff <= RST_NIBBLE;
    end else begin
      if (wr_status) status_hold_reg_ff <= wb_dat_i[7:0];
      if (wr_link) link_control_reg_ff <= wb_dat_i[7:0];
      if (wr_ctrl) ctrl_ff <= wb_dat_i[2:0];
      if (wr_mask) irq_mask_ff <= wb_dat_i[3:0];
    end
  end

  // -----------------------------------------------------------------
  // Command sequencer
  // -----------------------------------------------------------------
  // Disconnect and Reset commands are honoured in any state, so software
  // can always pull the device off a hung initiator.
  wire kill = wr_cmd && (cmd_code == CMD_DISCONNECT || cmd_code == CMD_RESET);
  wire go_0d = wr_cmd && (cmd_code == CMD_STATUS_COMPLETE);
  wire go_0e = wr_cmd && (cmd_code == CMD_DISCONNECT_MSG);
  wire halt = atn_s && halt_on_attention_bit;
  wire [7:0] msg_code = !link_control_reg_ff[0] ? MSG_CMD_COMPLETE :
    (link_control_reg_ff[1] ? MSG_LINKED_FLAG : MSG_LINKED);
  wire launch = (state_ff == S_STAT) || (state_ff == S_MSG) ||
    (state_ff == S_SDP) || (state_ff == S_DISC) || (state_ff == S_CDB);

  logic hs_start_ff;
  logic hs_dir_ff;
  logic [7:0] hs_byte_ff;
  logic bsy_ff;
  logic [2:0] lines_ff;
  logic [3:0] cdb_cnt_ff;
  logic [3:0] cdb_len_ff;
  logic hs_done;
  logic [7:0] hs_rx;
  // The group code comes from the captured byte, because the live bus
  // has already moved on when the handshake reports done.
  wire [2:0] grp = hs_rx[7:5];
  wire [3:0] len_first = (grp == 3'h1 || grp == 3'h2) ? CDB_LEN_10 :
    (grp == 3'h5) ? CDB_LEN_12 : CDB_LEN_6;

  sst_state_e nxt_state;
  sst_state_e nxt_cur;
  logic [7:0] nxt_phase;
  logic nxt_conn;
  logic nxt_bsy;
  logic [2:0] nxt_lines;
  logic nxt_hs_start;
  logic nxt_hs_dir;
  logic [7:0] nxt_hs_byte;
  logic [3:0] nxt_cdb_cnt;
  logic [3:0] nxt_cdb_len;
  logic nxt_cdb_valid;
  logic [3:0] irq_ev;

  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_phase = phase_ff;
    nxt_conn = conn_ff;
    nxt_bsy = bsy_ff;
    nxt_lines = lines_ff;
    nxt_hs_start = 1'b0;
    nxt_hs_dir = hs_dir_ff;
    nxt_hs_byte = hs_byte_ff;
    nxt_cdb_cnt = cdb_cnt_ff;
    nxt_cdb_len = cdb_len_ff;
    nxt_cdb_valid = 1'b0;
    irq_ev = 4'h0;
    if (kill) begin
      nxt_state = S_IDLE;
      nxt_conn = 1'b0;
      nxt_bsy = 1'b0;
      nxt_lines = 3'h0;
      irq_ev[IRQ_TERM_BIT] = 1'b1;
      if (cmd_code == CMD_RESET) nxt_phase = PH_NONE;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (wr_phase) nxt_phase = wb_dat_i[7:0];
          if (wr_ctrl) nxt_conn = wb_dat_i[CTRL_CONN_BIT];
          if (wr_ctrl) nxt_bsy = wb_dat_i[CTRL_CONN_BIT];
          if ((go_0d || go_0e) && !conn_ff) begin
            irq_ev[IRQ_INVALID_BIT] = 1'b1;
          end else if (go_0d) begin
            nxt_state = (phase_ff == PH_STATUS) ? S_MSG : S_STAT;
          end else if (go_0e) begin
            nxt_state = save_pointer_before_disconnect_bit ? S_SDP : S_DISC;
          end
        end
        S_STAT, S_MSG, S_SDP, S_DISC, S_CDB: begin
          if (halt) begin
            nxt_state = S_IDLE;
            irq_ev[IRQ_TERM_BIT] = 1'b1;
          end else begin
            nxt_hs_start = 1'b1;
            nxt_cur = state_ff;
            nxt_state = S_WAIT;
            nxt_hs_dir = (state_ff != S_CDB);
            nxt_lines = (state_ff == S_STAT) ? 3'b110 :
              (state_ff == S_CDB) ? 3'b100 : 3'b111;
            nxt_hs_byte = (state_ff == S_STAT) ? status_hold_reg_ff :
              (state_ff == S_MSG) ? msg_code :
              (state_ff == S_SDP) ? MSG_SAVE_PTR : MSG_DISCONNECT;
            if (state_ff == S_CDB && cdb_cnt_ff == 4'h0) nxt_phase = PH_CMD;
          end
        end
        S_WAIT: begin
          if (hs_done) begin
            case (cur_ff)
              S_STAT: begin
                nxt_phase = PH_STATUS;
                nxt_state = S_MSG;
              end
              S_MSG: begin
                if (link_control_reg_ff[0]) begin
                  nxt_phase = PH_LCC;
                  nxt_state = S_CDB;
                  nxt_cdb_cnt = 4'h0;
                  nxt_cdb_len = CDB_LEN_6;
                end else begin
                  nxt_phase = PH_CC;
                  nxt_state = S_IDLE;
                  nxt_conn = 1'b0;
                  nxt_bsy = 1'b0;
                  nxt_lines = 3'h0;
                  irq_ev[IRQ_DONE_BIT] = 1'b1;
                end
              end
              S_SDP: begin
                nxt_phase = PH_SDP;
                nxt_state = S_DISC;
              end
              S_DISC: begin
                nxt_phase = PH_DISC;
                nxt_state = S_FREE;
                nxt_bsy = 1'b0;
                nxt_lines = 3'h0;
              end
              S_CDB: begin
                nxt_cdb_valid = 1'b1;
                nxt_cdb_cnt = cdb_cnt_ff + 4'h1;
                nxt_phase = PH_CMD + {4'h0, cdb_cnt_ff + 4'h1};
                if (cdb_cnt_ff == 4'h0) nxt_cdb_len = len_first;
                if (cdb_cnt_ff + 4'h1 == ((cdb_cnt_ff == 4'h0) ?
                    len_first : cdb_len_ff)) begin
                  nxt_state = S_IDLE;
                  irq_ev[IRQ_DONE_BIT] = 1'b1;
                end else begin
                  nxt_state = S_CDB;
                end
              end
              default: nxt_state = S_IDLE;
            endcase
          end
        end
        S_FREE: begin
          nxt_phase = PH_FREE;
          nxt_conn = 1'b0;
          nxt_state = S_IDLE;
          irq_ev[IRQ_FREE_BIT] = 1'b1;
        end
        default: nxt_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      cur_ff <= S_IDLE;
      phase_ff <= PH_NONE;
      conn_ff <= 1'b0;
      bsy_ff <= 1'b0;
      lines_ff <= 3'h0;
      hs_start_ff <= 1'b0;
      hs_dir_ff <= 1'b0;
      hs_byte_ff <= RST_BYTE;
      cdb_cnt_ff <= RST_NIBBLE;
      cdb_len_ff <= RST_NIBBLE;
      cdb_valid_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      phase_ff <= nxt_phase;
      conn_ff <= nxt_conn;
      bsy_ff <= nxt_bsy;
      lines_ff <= nxt_lines;
      hs_start_ff <= nxt_hs_start;
      hs_dir_ff <= nxt_hs_dir;
      hs_byte_ff <= nxt_hs_byte;
      cdb_cnt_ff <= nxt_cdb_cnt;
      cdb_len_ff <= nxt_cdb_len;
      cdb_valid_o <= nxt_cdb_valid;
    end
  end
  assign scsi_bsy_o = bsy_ff;
  assign scsi_cd_o = lines_ff[2];
  assign scsi_io_o = lines_ff[1];
  assign scsi_msg_o = lines_ff[0];
  assign cdb_byte_o = hs_rx;

  sst_reqack u_hs (
    .clk(clk),
    .rst(rst),
    .start(hs_start_ff),
    .dir_out(hs_dir_ff),
    .tx_byte(hs_byte_ff),
    .abort(kill),
    .ack_s(ack_s),
    .db_s(db_s),
    .req(scsi_req_o),
    .db_o(scsi_db_o),
    .db_oe(scsi_db_oe),
    .rx_byte(hs_rx),
    .done(hs_done)
  );

  // -----------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------
  // A new event in the cycle of a clearing read survives the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_ff <= RST_NIBBLE;
      irq <= 1'b0;
    end else begin
      irq_status_ff <= (rd_irq ? 4'h0 : irq_status_ff) | irq_ev;
      irq <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  sequence s_chain;
    state_ff == S_CDB ##1 (phase_ff == PH_CMD && !scsi_io_o);
  endsequence
  sequence s_free;
    state_ff == S_FREE ##1 (phase_ff == PH_FREE && !conn_ff);
  endsequence

  property p_reject;
    @(posedge clk) disable iff (rst)
      (state_ff == S_IDLE && go_0d && !conn_ff && !kill) |=>
        (state_ff == S_IDLE && irq_status_ff[IRQ_INVALID_BIT]);
  endproperty
  a_reject: assert property (p_reject)
    else $error("0D accepted while not connected");

  property p_status_byte;
    @(posedge clk) disable iff (rst)
      (state_ff == S_STAT && !halt && !kill) |=>
        (hs_byte_ff == status_hold_reg_ff && lines_ff == 3'b110);
  endproperty
  a_status_byte: assert property (p_status_byte)
    else $error("status byte or phase lines wrong");

  property p_msg_code;
    @(posedge clk) disable iff (rst)
      (state_ff == S_MSG && !halt && !kill) |=>
        (hs_byte_ff == (!link_control_reg_ff[0] ? 8'h00 :
          (link_control_reg_ff[1] ? 8'h0B : 8'h0A)));
  endproperty
  a_msg_code: assert property (p_msg_code)
    else $error("wrong completion message");

  property p_halt;
    @(posedge clk) disable iff (rst)
      (launch && halt && !kill) |=>
        (state_ff == S_IDLE && irq_status_ff[IRQ_TERM_BIT] && !scsi_req_o);
  endproperty
  a_halt: assert property (p_halt)
    else $error("attention did not terminate");

  property p_phase50;
    @(posedge clk) disable iff (rst)
      (state_ff == S_WAIT && cur_ff == S_STAT && hs_done && !kill) |=>
        (phase_ff == PH_STATUS && state_ff == S_MSG);
  endproperty
  a_phase50: assert property (p_phase50)
    else $error("progress not 50 after status");

  property p_resume;
    @(posedge clk) disable iff (rst)
      (state_ff == S_IDLE && go_0d && conn_ff && phase_ff == PH_STATUS &&
        !kill) |=> state_ff == S_MSG;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not start at message");

  property p_free;
    @(posedge clk) disable iff (rst)
      (state_ff == S_WAIT && cur_ff == S_DISC && hs_done && !kill) ##1
        !kill |-> (phase_ff == PH_DISC && !scsi_bsy_o) ##0 s_free
        ##0 irq_status_ff[IRQ_FREE_BIT];
  endproperty
  a_free: assert property (p_free)
    else $error("disconnect sequence wrong");

  property p_sdp;
    @(posedge clk) disable iff (rst)
      (state_ff == S_IDLE && go_0e && conn_ff &&
        save_pointer_before_disconnect_bit && !kill) |=> state_ff == S_SDP;
  endproperty
  a_sdp: assert property (p_sdp)
    else $error("save pointer not sent first");

  property p_chain;
    @(posedge clk) disable iff (rst)
      (state_ff == S_WAIT && cur_ff == S_MSG && hs_done &&
        link_control_reg_ff[0] && !kill) ##1 (!halt && !kill) |->
        phase_ff == PH_LCC ##0 s_chain;
  endproperty
  a_chain: assert property (p_chain)
    else $error("linked completion did not chain");

  property p_wb_ack;
    @(posedge clk) disable iff (rst)
      wb_hit |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not a single cycle");
endmodule

//--- bench/sst_init_model.sv
// Initiator model for the target sequencer's SCSI side.
// Assumes REQ, I/O and data come straight from the sequencer's outputs.
`timescale 1ns/1ns
module sst_init_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic io,
  input wire logic cd,
  input wire logic msg,
  input wire logic oe,
  input wire logic [7:0] db_o,
  input wire logic [7:0] cmd_byte,
  input wire logic [3:0] delay,
  output logic ack,
  output logic [7:0] db_i,
  output logic [15:0] hist,
  output logic [7:0] lines,
  output logic [7:0] nbytes
);
  logic [3:0] wait_ff;
  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  // A released data line shows the inverse of its last value.
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
      wait_ff <= 4'h0;
      hist <= 16'h0000;
      lines <= 8'h00;
      nbytes <= 8'h00;
      db_i <= 8'h00;
    end else begin
      db_i <= (req && !io) ? cmd_byte : ~db_i;
      if (req && !ack) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff >= delay) begin
          ack <= 1'b1;
          wait_ff <= 4'h0;
          if (io) begin
            hist <= {hist[7:0], db_o};
            lines <= {lines[3:0], oe, cd, io, msg};
            nbytes <= nbytes + 8'h01;
          end
        end
      end else if (!req) begin
        ack <= 1'b0;
        wait_ff <= 4'h0;
      end
    end
  end
endmodule

//--- bench/sst_top_test.sv
// Self-checking bench for the target status/disconnect sequencer.
// Assumes sst_init_model answers as the initiator.
`timescale 1ns/1ns
module sst_top_test;
  import sst_pkg::*;
  logic clk = 1'b0, rst = 1'b1, atn = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00, q, n0, c0, cdb_cnt = 8'h00;
  logic [7:0] cmd = 8'h08, cdb_last = 8'h00, lines;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic [3:0] delay = 4'h1;
  logic wb_ack_o, irq, ack, req, oe, bsy, cd, io, msg, cdb_v;
  logic [7:0] db_o, db_i, cdb_b, nbytes;
  logic [15:0] hist;
  int failures = 0, checked = 0, cycles = 0;
  sst_top sst_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .scsi_ack_i(ack), .scsi_atn_i(atn),
    .scsi_db_i(db_i), .scsi_db_o(db_o), .scsi_db_oe(oe),
    .scsi_req_o(req), .scsi_bsy_o(bsy), .scsi_cd_o(cd), .scsi_io_o(io),
    .scsi_msg_o(msg), .cdb_byte_o(cdb_b), .cdb_valid_o(cdb_v));
  sst_init_model sst_init_model_inst (.clk(clk), .rst(rst), .req(req),
    .io(io), .cd(cd), .msg(msg), .oe(oe), .db_o(db_o), .cmd_byte(cmd),
    .delay(delay), .ack(ack), .db_i(db_i), .hist(hist), .lines(lines),
    .nbytes(nbytes));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cdb_cnt <= rst ? 8'h00 : cdb_cnt + {7'h0, cdb_v};
    if (cdb_v === 1'b1) cdb_last <= cdb_b;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked = checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The slave answers in its own time; only the global timeout ends it.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    while (irq !== 1'b1) @(posedge clk);
  endtask
  task automatic start(input logic [7:0] ctrl, input logic [7:0] ph);
    wb(1'b1, OFS_CTRL, ctrl);
    wb(1'b1, OFS_PHASE, ph);
    n0 = nbytes;
    c0 = cdb_cnt;
  endtask
  task automatic done(input logic [7:0] st, input logic [7:0] ph);
    wb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk("irq status", st, q);
    wb(1'b0, OFS_PHASE, 8'h00);
    chk("phase", ph, q);
    wb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk("status cleared", 8'h00, q);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_refuse();
    wb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 8'h00, q);
    wb(1'b1, OFS_CMD, CMD_STATUS_COMPLETE);
    repeat (4) @(posedge clk);
    chk("masked irq", 8'h00, {7'h0, irq});
    wb(1'b1, OFS_IRQ_MASK, 8'h0F);
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    done(8'h08, PH_NONE);
    chk("sent", 8'h00, nbytes);
  endtask
  task automatic t_complete(input logic [7:0] lk, input logic [7:0] m,
    input logic [7:0] c, input logic [7:0] n);
    cmd <= c;
    start(8'h08, PH_NONE);
    wb(1'b1, OFS_STATUS_HOLD, 8'hA5 ^ lk);
    wb(1'b1, OFS_LINK_CTRL, lk);
    wb(1'b1, OFS_CMD, CMD_STATUS_COMPLETE);
    wait_irq();
    chk("status byte", 8'hA5 ^ lk, hist[15:8]);
    chk("message", m, hist[7:0]);
    chk("phase lines", 8'hEF, lines);
    chk("cdb bytes", n, cdb_cnt - c0);
    if (n != 8'h00) chk("cdb byte", c, cdb_last);
    done(8'h01, (n != 8'h00) ? PH_CMD + n : PH_CC);
  endtask
  // Without the save pointer the byte before is the last run's Disconnect.
  task automatic t_disc(input logic sdp);
    start({4'h0, 2'b10, sdp, 1'b0}, PH_NONE);
    wb(1'b1, OFS_CMD, CMD_DISCONNECT_MSG);
    wait_irq();
    chk("bytes", {7'h0, sdp} + 8'h01, nbytes - n0);
    chk("first", sdp ? MSG_SAVE_PTR : MSG_DISCONNECT, hist[15:8]);
    chk("disconnect", MSG_DISCONNECT, hist[7:0]);
    chk("phase lines", 8'hFF, lines);
    chk("bsy", 8'h00, {7'h0, bsy});
    done(8'h02, PH_FREE);
  endtask
  task automatic t_resume();
    start(8'h08, PH_STATUS);
    wb(1'b1, OFS_LINK_CTRL, 8'h00);
    wb(1'b1, OFS_CMD, CMD_STATUS_COMPLETE);
    wait_irq();
    chk("bytes", 8'h01, nbytes - n0);
    chk("message", MSG_CMD_COMPLETE, hist[7:0]);
    done(8'h01, PH_CC);
  endtask
  task automatic t_atn(input logic [7:0] c);
    start(8'h09, PH_NONE);
    atn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, OFS_CMD, c);
    wait_irq();
    atn <= 1'b0;
    chk("bytes", 8'h00, nbytes - n0);
    done(8'h04, PH_NONE);
  endtask
  task automatic t_abort(input logic [7:0] c, input logic [7:0] stop);
    delay <= 4'hF;
    start(8'h08, PH_NONE);
    wb(1'b1, OFS_CMD, c);
    while (req !== 1'b1) @(posedge clk);
    wb(1'b1, OFS_CMD, stop);
    wait_irq();
    chk("req", 8'h00, {7'h0, req});
    done(8'h04, PH_NONE);
    delay <= 4'h1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, OFS_PHASE, 8'h00);
    chk("reset phase", PH_NONE, q);
    wb(1'b1, OFS_IRQ_MASK, 8'h00);
    t_refuse();
    t_complete(8'h00, MSG_CMD_COMPLETE, 8'h08, 8'h00);
    t_complete(8'h02, MSG_CMD_COMPLETE, 8'h08, 8'h00);
    t_complete(8'h01, MSG_LINKED, 8'h08, 8'h06);
    t_complete(8'h03, MSG_LINKED_FLAG, 8'h28, 8'h0A);
    t_complete(8'h01, MSG_LINKED, 8'hA8, 8'h0C);
    t_disc(1'b1);
    t_disc(1'b0);
    t_resume();
    t_atn(CMD_STATUS_COMPLETE);
    t_atn(CMD_DISCONNECT_MSG);
    t_abort(CMD_STATUS_COMPLETE, CMD_DISCONNECT);
    t_abort(CMD_DISCONNECT_MSG, CMD_RESET);
    finish_test();
  end
endmodule
